// ===== verilog/a4t_pkg.sv
/*
 * Shared constants, types and register map of the transmit and loopback
 * block. Assumes a 250 MHz system clock from which the 1 MHz data clock
 * is derived.
 */
`default_nettype none

package a4t_pkg;

	// Clocking: every serial timing figure counts data clock ticks.
	localparam int unsigned SYS_CLK_HZ  = 250_000_000;
	localparam int unsigned DATA_CLK_HZ = 1_000_000;
	localparam int unsigned TICK_DIV    = SYS_CLK_HZ / DATA_CLK_HZ;
	localparam logic [7:0]  TICK_LAST   = 8'(TICK_DIV - 1);

	// Serial timing in data clocks.
	localparam logic [8:0] HS_HALF_CLKS = 9'h005;
	localparam logic [8:0] LS_HALF_CLKS = 9'h028;
	localparam logic [8:0] HS_GAP_CLKS  = 9'h028;
	localparam logic [8:0] LS_GAP_CLKS  = 9'h140;
	localparam logic [4:0] LAST_BIT     = 5'h1F;

	// FIFO geometry.
	localparam int unsigned WORD_W     = 32;
	localparam int unsigned PTR_W      = 5;
	localparam int unsigned CNT_W      = 6;
	localparam int unsigned RX_COUNT   = 2;
	localparam logic [5:0]  FIFO_FULL  = 6'h20;
	localparam logic [5:0]  FIFO_HALF  = 6'h10;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_CMD       = 8'h04;
	localparam logic [7:0] REG_STATUS    = 8'h08;
	localparam logic [7:0] REG_TX_LOW    = 8'h0C;
	localparam logic [7:0] REG_TX_HIGH   = 8'h10;
	localparam logic [7:0] REG_RX_BASE   = 8'h14;
	localparam logic [7:0] REG_RX_STRIDE = 8'h08;
	localparam logic [7:0] REG_HIGH_OFS  = 8'h04;

	// Control register: bit 0 is parity enable, upward as in the struct.
	localparam int unsigned CTRL_W     = 6;
	localparam logic [5:0]  CTRL_RESET = 6'h05;
	localparam int unsigned CMD_MR_BIT = 0;

	// Status register bit positions.
	localparam int unsigned ST_TX_READY   = 0;
	localparam int unsigned ST_TX_HALF_N  = 1;
	localparam int unsigned ST_TX_FULL_N  = 2;
	localparam int unsigned ST_RX_RDY_N   = 3;
	localparam int unsigned ST_TX_BUSY    = 5;

	typedef struct packed {
		logic repeater_mode;
		logic tx_speed_low;
		logic transmit_enable;
		logic self_test_n_bit;
		logic parity_sense_bit;
		logic parity_enable_bit;
	} a4t_ctrl_t;

	typedef struct packed {
		logic pos;
		logic neg;
	} a4t_line_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_LOAD = 3'h1,
		TX_WAIT = 3'h2,
		TX_DATA = 3'h3,
		TX_NULL = 3'h4,
		TX_GAP  = 3'h5
	} a4t_tx_state_t;

endpackage : a4t_pkg

`default_nettype wire

// ===== verilog/a4t_word_mem.sv
/*
 * Word memory of 32 entries with one write port and one registered read
 * port. Assumes a single clock; read data lag the read address by one edge.
 */
`timescale 1ns/1ns
`default_nettype none

module a4t_word_mem (
	input  wire logic                        sys_clk_in,
	input  wire logic                        rstn_in,
	input  wire logic                        wr_en_in,
	input  wire logic [a4t_pkg::PTR_W-1:0]   wr_addr_in,
	input  wire logic [a4t_pkg::WORD_W-1:0]  wr_data_in,
	input  wire logic [a4t_pkg::PTR_W-1:0]   rd_addr_in,
	output logic      [a4t_pkg::WORD_W-1:0]  rd_data_out
);
	import a4t_pkg::*;

	logic [WORD_W-1:0] mem [0:(1<<PTR_W)-1];

	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_data_out <= '0;
		end else begin
			rd_data_out <= mem[rd_addr_in];
		end
	end

endmodule : a4t_word_mem

`default_nettype wire

// ===== verilog/a4t_top.sv
/*
 * Transmit FIFO, serialiser, self-test loopback, two receive FIFOs and
 * repeater path, reached over a classic Wishbone slave. Assumes receiver
 * decode logic on the same clock delivering whole words, and an external
 * line driver on the two serial outputs.
 */
// Summary of operation
// RULE1: half-full flag high below 16 words
// RULE2: parity enable selects parity or data bit
// RULE3: parity odd if sense low, even if high
// RULE4: enable starts word, first bit promptly
// RULE5: high speed: 5+5 clock bits, 40 gap
// RULE6: low speed: 40+40 clock bits, 320 gap
// RULE7: ready flag high when all words sent
// RULE8: self-test low loops transmit into receivers
// RULE9: receiver two gets inverted loopback stream
// RULE10: transmit outputs always carry serial stream
// RULE11: full receive FIFO overwrites newest location
// RULE12: transmit FIFO holds 32, ignores extra loads
// RULE13: host may read either half first
// RULE14: repeater copies read words into transmit FIFO; code copies only words read low half first
// RULE15: master reset stops all, empties FIFOs
// RULE16: master reset leaves control register alone
// RULE17: data ready falls promptly after word
// RULE18: host loads low half, then high half
// RULE19: ready high means transmit FIFO empty
// RULE20: separate transmit speed select chooses timing
`timescale 1ns/1ns
`default_nettype none

module a4t_top (
	input  wire logic                                 sys_clk_in,
	input  wire logic                                 rstn_in,
	input  wire logic                                 wb_cyc_in,
	input  wire logic                                 wb_stb_in,
	input  wire logic                                 wb_we_in,
	input  wire logic [7:0]                           wb_adr_in,
	input  wire logic [3:0]                           wb_sel_in,
	input  wire logic [31:0]                          wb_dat_in,
	output logic      [31:0]                          wb_dat_out,
	output logic                                      wb_ack_out,
	input  wire logic [a4t_pkg::RX_COUNT-1:0]         rx_word_valid_in,
	input  wire logic [a4t_pkg::RX_COUNT-1:0][31:0]   rx_word_in,
	input  wire a4t_pkg::a4t_line_t [a4t_pkg::RX_COUNT-1:0] rx_line_in,
	output a4t_pkg::a4t_line_t [a4t_pkg::RX_COUNT-1:0] rx_line_out,
	output logic                                      serial_out_pos_out,
	output logic                                      serial_out_neg_out,
	output logic                                      tx_ready_out,
	output logic                                      tx_half_full_n_out,
	output logic                                      tx_fifo_full_n_out,
	output logic      [a4t_pkg::RX_COUNT-1:0]         rx_data_ready_n_out
);
	import a4t_pkg::*;

	function automatic logic [7:0] rx_addr(input int idx, input logic high);
		logic [7:0] a;
		a = 8'(REG_RX_BASE + 8'(idx) * REG_RX_STRIDE);
		return high ? 8'(a + REG_HIGH_OFS) : a;
	endfunction : rx_addr

	function automatic logic [31:0] apply_parity(input logic [31:0] w,
	                                              input a4t_ctrl_t c);
		logic [31:0] r;
		r = w;
		if (c.parity_enable_bit) begin
			r[31] = c.parity_sense_bit ? ^w[30:0] : ~^w[30:0]; // RULE3
		end
		return r; // RULE2
	endfunction : apply_parity

	logic                     ack_reg;
	logic [31:0]              dat_reg;
	logic [31:0]              rd_data;
	logic                     req;
	logic                     acc_wr;
	logic                     acc_rd;
	logic [7:0]               adr;
	logic                     mr_pulse;
	a4t_ctrl_t                ctrl_reg;
	logic [15:0]              tx_low_reg;
	logic                     host_push;
	logic                     rep_push;
	logic [31:0]              rep_word;
	logic                     tx_push;
	logic                     tx_pop;
	logic [31:0]              tx_word;
	logic [PTR_W-1:0]         tx_wr_ptr_reg;
	logic [PTR_W-1:0]         tx_rd_ptr_reg;
	logic [CNT_W-1:0]         tx_cnt_reg;
	logic [31:0]              tx_q;
	logic                     tx_full;
	logic [7:0]               tick_cnt_reg;
	logic                     tick;
	a4t_tx_state_t            state_reg;
	logic [31:0]              shift_reg;
	logic [4:0]               bit_idx_reg;
	logic [8:0]               phase_reg;
	logic [8:0]               half_clks;
	logic [8:0]               gap_clks;
	logic                     tx_ready_reg;
	logic                     pos_reg;
	logic                     neg_reg;
	logic                     half_n_reg;
	logic                     full_n_reg;
	a4t_line_t [RX_COUNT-1:0] sync1_reg;
	a4t_line_t [RX_COUNT-1:0] sync2_reg;
	a4t_line_t [RX_COUNT-1:0] line_reg;
	logic [RX_COUNT-1:0]      rdy_n_reg;
	logic [RX_COUNT-1:0]      rx_rep_push;
	logic [RX_COUNT-1:0][31:0] rx_q;

	assign req      = wb_cyc_in & wb_stb_in;
	assign acc_wr   = req & ack_reg & wb_we_in;
	assign acc_rd   = req & ack_reg & ~wb_we_in;
	assign adr      = {wb_adr_in[7:2], 2'b00};
	// Acting on the command write itself clears FIFOs, flags and serialiser in that edge; control is kept.
	assign mr_pulse = acc_wr & (adr == REG_CMD) & wb_sel_in[0]
	                & wb_dat_in[CMD_MR_BIT]; // RULE15

	// Wishbone slave: ack one cycle after the strobe, effects at the ack edge.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (req & ~ack_reg) begin
				dat_reg <= rd_data;
			end
		end
	end

	always_comb begin
		rd_data = '0;
		case (adr)
			REG_CTRL: begin
				rd_data[CTRL_W-1:0] = ctrl_reg;
			end
			REG_STATUS: begin
				rd_data[ST_TX_READY]  = tx_ready_reg;
				rd_data[ST_TX_HALF_N] = half_n_reg;
				rd_data[ST_TX_FULL_N] = full_n_reg;
				rd_data[ST_TX_BUSY]   = (state_reg != TX_IDLE);
				rd_data[ST_RX_RDY_N +: RX_COUNT] = rdy_n_reg;
			end
			REG_TX_LOW: begin
				rd_data[15:0] = tx_low_reg;
			end
			default: begin
				for (int i = 0; i < RX_COUNT; i++) begin
					if (adr == rx_addr(i, 1'b0)) begin
						rd_data[15:0] = rx_q[i][15:0]; // RULE13
					end
					if (adr == rx_addr(i, 1'b1)) begin
						rd_data[15:0] = rx_q[i][31:16]; // RULE13
					end
				end
			end
		endcase
	end

	// Of the two resets, only the power-on reset touches the control register.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_reg <= a4t_ctrl_t'(CTRL_RESET);
		end else if (acc_wr & (adr == REG_CTRL) & wb_sel_in[0]) begin
			ctrl_reg <= a4t_ctrl_t'(wb_dat_in[CTRL_W-1:0]); // RULE16
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_low_reg <= '0;
		end else if (acc_wr & (adr == REG_TX_LOW) & (&wb_sel_in[1:0])) begin
			tx_low_reg <= wb_dat_in[15:0]; // RULE18
		end
	end

	assign host_push = acc_wr & (adr == REG_TX_HIGH) & (&wb_sel_in[1:0]);
	assign tx_full   = (tx_cnt_reg == FIFO_FULL);
	assign tx_push   = (host_push | rep_push) & ~tx_full & ~mr_pulse; // RULE12
	assign tx_word   = host_push ? {wb_dat_in[15:0], tx_low_reg} : rep_word;
	assign tx_pop    = (state_reg == TX_LOAD);

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_wr_ptr_reg <= '0;
			tx_rd_ptr_reg <= '0;
			tx_cnt_reg    <= '0;
		end else if (mr_pulse) begin
			tx_wr_ptr_reg <= '0; // RULE15
			tx_rd_ptr_reg <= '0;
			tx_cnt_reg    <= '0;
		end else begin
			if (tx_push) begin
				tx_wr_ptr_reg <= tx_wr_ptr_reg + 1'b1;
			end
			if (tx_pop) begin
				tx_rd_ptr_reg <= tx_rd_ptr_reg + 1'b1;
			end
			if (tx_push & ~tx_pop) begin
				tx_cnt_reg <= tx_cnt_reg + 1'b1;
			end else if (tx_pop & ~tx_push) begin
				tx_cnt_reg <= tx_cnt_reg - 1'b1;
			end
		end
	end

	a4t_word_mem u_tx_mem (
		.sys_clk_in  (sys_clk_in),
		.rstn_in     (rstn_in),
		.wr_en_in    (tx_push),
		.wr_addr_in  (tx_wr_ptr_reg),
		.wr_data_in  (tx_word),
		.rd_addr_in  (tx_rd_ptr_reg),
		.rd_data_out (tx_q)
	);

	// Flags follow the count one edge later so that they come from flops.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			half_n_reg <= 1'b1;
			full_n_reg <= 1'b1;
		end else if (mr_pulse) begin
			half_n_reg <= 1'b1;
			full_n_reg <= 1'b1;
		end else begin
			half_n_reg <= (tx_cnt_reg < FIFO_HALF); // RULE1
			full_n_reg <= ~tx_full; // RULE12
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tick_cnt_reg <= '0;
		end else if (tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end

	assign tick      = (tick_cnt_reg == TICK_LAST);
	// Speed is read live; changing it mid-word distorts that word only.
	assign half_clks = ctrl_reg.tx_speed_low ? LS_HALF_CLKS : HS_HALF_CLKS; // RULE20
	assign gap_clks  = ctrl_reg.tx_speed_low ? LS_GAP_CLKS : HS_GAP_CLKS; // RULE20

	// Serialiser. The gap ends one tick early because the next word waits
	// for a tick in TX_WAIT, so the quiet time is exactly the gap figure.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg   <= TX_IDLE;
			shift_reg   <= '0;
			bit_idx_reg <= '0;
			phase_reg   <= '0;
			pos_reg     <= 1'b0;
			neg_reg     <= 1'b0;
		end else if (mr_pulse) begin
			state_reg <= TX_IDLE; // RULE15
			pos_reg   <= 1'b0;
			neg_reg   <= 1'b0;
		end else begin
			case (state_reg)
				TX_IDLE: begin
					if (ctrl_reg.transmit_enable && tx_cnt_reg != '0) begin
						state_reg <= TX_LOAD; // RULE4
					end
				end
				TX_LOAD: begin
					shift_reg <= apply_parity(tx_q, ctrl_reg); // RULE2
					state_reg <= TX_WAIT; // RULE4
				end
				TX_WAIT: begin
					if (tick) begin
						bit_idx_reg <= '0;
						phase_reg   <= '0;
						pos_reg     <= shift_reg[0]; // RULE4
						neg_reg     <= ~shift_reg[0];
						state_reg   <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tick) begin
						if (phase_reg == 9'(half_clks - 1'b1)) begin
							phase_reg <= '0; // RULE5 RULE6
							pos_reg   <= 1'b0;
							neg_reg   <= 1'b0;
							state_reg <= TX_NULL;
						end else begin
							phase_reg <= phase_reg + 1'b1;
						end
					end
				end
				TX_NULL: begin
					if (tick) begin
						if (phase_reg != 9'(half_clks - 1'b1)) begin
							phase_reg <= phase_reg + 1'b1;
						end else if (bit_idx_reg == LAST_BIT) begin
							phase_reg <= '0;
							state_reg <= TX_GAP;
						end else begin
							phase_reg   <= '0; // RULE5 RULE6
							bit_idx_reg <= bit_idx_reg + 1'b1;
							shift_reg   <= {1'b0, shift_reg[31:1]};
							pos_reg     <= shift_reg[1];
							neg_reg     <= ~shift_reg[1];
							state_reg   <= TX_DATA;
						end
					end
				end
				TX_GAP: begin
					if (tick) begin
						if (phase_reg == 9'(gap_clks - 9'h002)) begin
							phase_reg <= '0; // RULE5 RULE6
							if (ctrl_reg.transmit_enable && tx_cnt_reg != '0) begin
								state_reg <= TX_LOAD;
							end else begin
								state_reg <= TX_IDLE;
							end
						end else begin
							phase_reg <= phase_reg + 1'b1;
						end
					end
				end
				default: begin
					state_reg <= TX_IDLE;
				end
			endcase
		end
	end

	// Ready is a loaded-versus-sent check; a load in the same edge keeps it low.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_ready_reg <= 1'b1;
		end else if (mr_pulse) begin
			tx_ready_reg <= 1'b1; // RULE15 RULE19
		end else if (tx_push) begin
			tx_ready_reg <= 1'b0;
		end else if (state_reg == TX_NULL && tick && bit_idx_reg == LAST_BIT
		             && phase_reg == 9'(half_clks - 1'b1)
		             && tx_cnt_reg == '0) begin
			tx_ready_reg <= 1'b1; // RULE7 RULE19
		end
	end

	// Line inputs are pins: two flops before the loopback mux reads them.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			line_reg  <= '0;
		end else begin
			sync1_reg <= rx_line_in;
			sync2_reg <= sync1_reg;
			if (ctrl_reg.self_test_n_bit) begin
				line_reg <= sync2_reg;
			end else begin
				line_reg[0] <= '{pos: pos_reg, neg: neg_reg}; // RULE8
				line_reg[1] <= '{pos: neg_reg, neg: pos_reg}; // RULE8 RULE9
			end
		end
	end

	// Receive FIFOs: a word pops once both halves have been read.
	for (genvar g = 0; g < RX_COUNT; g++) begin : g_rx
		logic [PTR_W-1:0] wr_ptr_reg;
		logic [PTR_W-1:0] rd_ptr_reg;
		logic [CNT_W-1:0] cnt_reg;
		logic             lo_seen_reg;
		logic             hi_seen_reg;
		logic             rd_lo;
		logic             rd_hi;
		logic             pop;
		logic             push;
		logic             full;
		logic             overwrite;
		logic [PTR_W-1:0] wr_addr;

		assign rd_lo     = acc_rd & (adr == rx_addr(g, 1'b0));
		assign rd_hi     = acc_rd & (adr == rx_addr(g, 1'b1));
		assign pop       = ((rd_lo & hi_seen_reg) | (rd_hi & lo_seen_reg))
		                 & (cnt_reg != '0) & ~mr_pulse; // RULE13
		assign push      = rx_word_valid_in[g] & ~mr_pulse;
		assign full      = (cnt_reg == FIFO_FULL);
		assign overwrite = push & full & ~pop;
		assign wr_addr   = overwrite ? PTR_W'(wr_ptr_reg - 1'b1) : wr_ptr_reg; // RULE11
		// Repeater copies only a word read low half first.
		assign rx_rep_push[g] = ctrl_reg.repeater_mode & rd_hi & pop; // RULE14

		always_ff @(posedge sys_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				wr_ptr_reg  <= '0;
				rd_ptr_reg  <= '0;
				cnt_reg     <= '0;
				lo_seen_reg <= 1'b0;
				hi_seen_reg <= 1'b0;
			end else if (mr_pulse) begin
				wr_ptr_reg  <= '0; // RULE15
				rd_ptr_reg  <= '0;
				cnt_reg     <= '0;
				lo_seen_reg <= 1'b0;
				hi_seen_reg <= 1'b0;
			end else begin
				if (push & ~overwrite) begin
					wr_ptr_reg <= wr_ptr_reg + 1'b1;
				end
				if (pop) begin
					rd_ptr_reg  <= rd_ptr_reg + 1'b1;
					lo_seen_reg <= 1'b0;
					hi_seen_reg <= 1'b0;
				end else begin
					lo_seen_reg <= lo_seen_reg | rd_lo;
					hi_seen_reg <= hi_seen_reg | rd_hi;
				end
				if (push & ~overwrite & ~pop) begin
					cnt_reg <= cnt_reg + 1'b1;
				end else if (pop & ~push) begin
					cnt_reg <= cnt_reg - 1'b1;
				end
			end
		end

		always_ff @(posedge sys_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				rdy_n_reg[g] <= 1'b1;
			end else if (mr_pulse) begin
				rdy_n_reg[g] <= 1'b1; // RULE15
			end else begin
				rdy_n_reg[g] <= (cnt_reg == '0); // RULE17
			end
		end

		a4t_word_mem u_rx_mem (
			.sys_clk_in  (sys_clk_in),
			.rstn_in     (rstn_in),
			.wr_en_in    (push),
			.wr_addr_in  (wr_addr),
			.wr_data_in  (rx_word_in[g]),
			.rd_addr_in  (rd_ptr_reg),
			.rd_data_out (rx_q[g])
		);
	end

	always_comb begin
		rep_push = 1'b0;
		rep_word = '0;
		for (int i = 0; i < RX_COUNT; i++) begin
			if (rx_rep_push[i]) begin
				rep_push = 1'b1; // RULE14
				rep_word = rx_q[i];
			end
		end
	end

	assign wb_ack_out          = ack_reg;
	assign wb_dat_out          = dat_reg;
	assign serial_out_pos_out  = pos_reg; // RULE10
	assign serial_out_neg_out  = neg_reg; // RULE10
	assign tx_ready_out        = tx_ready_reg;
	assign tx_half_full_n_out  = half_n_reg;
	assign tx_fifo_full_n_out  = full_n_reg;
	assign rx_data_ready_n_out = rdy_n_reg;
	assign rx_line_out         = line_reg;

endmodule : a4t_top

`default_nettype wire

// ===== bench/a4t_props.sv
/* Port checker for the transmit and loopback block.
 * Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module a4t_props (
	input wire logic                         sys_clk_in,
	input wire logic                         rstn_in,
	input wire logic                         wb_cyc_in,
	input wire logic                         wb_stb_in,
	input wire logic                         wb_ack_out,
	input wire logic [a4t_pkg::RX_COUNT-1:0] rx_word_valid_in,
	input wire logic [a4t_pkg::RX_COUNT-1:0] rx_data_ready_n_out,
	input wire logic                         serial_out_pos_out,
	input wire logic                         serial_out_neg_out,
	input wire logic                         tx_ready_out,
	input wire logic                         tx_half_full_n_out,
	input wire logic                         tx_fifo_full_n_out
);
	import a4t_pkg::*;
	logic        act;
	logic        act_reg;
	logic        word_reg;
	logic [16:0] run_reg;
	assign act = serial_out_pos_out | serial_out_neg_out;
	// Run length of act up to the previous sample; idle before the first
	// word is excluded because its length depends only on software.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			act_reg  <= 1'b0;
			word_reg <= 1'b0;
			run_reg  <= 17'h00000;
		end else begin
			act_reg  <= act;
			word_reg <= word_reg | act;
			if (act != act_reg)
				run_reg <= 17'h00001;
			else if (run_reg != 17'h1FFFF)
				run_reg <= run_reg + 17'h00001;
		end
	end
	default clocking dc @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence s_ack_once;
		wb_ack_out ##1 !wb_ack_out;
	endsequence
	data_len_a: assert property ($fell(act) |->
		run_reg == 17'h004E2 || run_reg == 17'h02710)
		else $error("data phase length wrong");
	null_len_a: assert property ($rose(act) && word_reg |->
		run_reg == 17'h004E2 || run_reg == 17'h02710 ||
		run_reg >= 17'h02BF2) else $error("null or gap too short");
	lines_excl_a: assert property (!(serial_out_pos_out &&
		serial_out_neg_out)) else $error("both lines high");
	ready_quiet_a: assert property (tx_ready_out |-> !act)
		else $error("ready while sending");
	ready_empty_a: assert property (tx_ready_out |->
		tx_half_full_n_out && tx_fifo_full_n_out)
		else $error("ready with words queued");
	full_half_a: assert property (!tx_fifo_full_n_out |->
		!tx_half_full_n_out) else $error("full but not half full");
	ack_follow_a: assert property (s_req |=> s_ack_once)
		else $error("ack not one cycle after request");
	rx_ready_a: assert property (rx_word_valid_in[0] && !wb_cyc_in |->
		##2 !rx_data_ready_n_out[0]) else $error("data ready late");
endmodule : a4t_props
bind a4t_top a4t_props i_a4t_props (
	.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
	.rx_word_valid_in(rx_word_valid_in),
	.rx_data_ready_n_out(rx_data_ready_n_out),
	.serial_out_pos_out(serial_out_pos_out),
	.serial_out_neg_out(serial_out_neg_out), .tx_ready_out(tx_ready_out),
	.tx_half_full_n_out(tx_half_full_n_out),
	.tx_fifo_full_n_out(tx_fifo_full_n_out));
`default_nettype wire

// ===== bench/a4t_line_model.sv
/* Line driver side model: decodes the serial pair and both loopback
 * streams into words, LSB first. Assumes the block's clock. */
`timescale 1ns/1ns
`default_nettype none
module a4t_line_model (
	input  wire logic                     sys_clk_in,
	input  wire logic                     rstn_in,
	input  wire logic                     pos_in,
	input  wire logic                     neg_in,
	input  wire a4t_pkg::a4t_line_t [1:0] loop_in,
	output a4t_pkg::a4t_line_t [1:0]      line_out,
	output logic [31:0]                   word_out,
	output logic [31:0]                   loop0_out,
	output logic [31:0]                   loop1_out
);
	import a4t_pkg::*;
	logic a_reg;
	logic b_reg;
	logic c_reg;
	// The external bus rests at null, so it must not leak into loopback.
	assign line_out = '0;
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			a_reg <= 1'b0;
			b_reg <= 1'b0;
			c_reg <= 1'b0;
			word_out <= '0;
			loop0_out <= '0;
			loop1_out <= '0;
		end else begin
			a_reg <= pos_in | neg_in;
			b_reg <= loop_in[0].pos | loop_in[0].neg;
			c_reg <= loop_in[1].pos | loop_in[1].neg;
			if ((pos_in | neg_in) && !a_reg)
				word_out <= {pos_in, word_out[31:1]};
			if ((loop_in[0].pos | loop_in[0].neg) && !b_reg)
				loop0_out <= {loop_in[0].pos, loop0_out[31:1]};
			if ((loop_in[1].pos | loop_in[1].neg) && !c_reg)
				loop1_out <= {loop_in[1].neg, loop1_out[31:1]};
		end
	end
endmodule : a4t_line_model
`default_nettype wire

// ===== bench/arinc429_transmit_loopback_tb.sv
/* Self-checking bench: registers, transmit FIFO flags, receive overflow,
 * repeater copy and one looped-back word. Assumes package and model. */
`timescale 1ns/1ns
`default_nettype none
module arinc429_transmit_loopback_tb;
	import a4t_pkg::*;
	logic              clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic              we = 1'b0, ack, pos, neg, rdy, hn, fn, sense;
	logic [7:0]        adr = 8'h00;
	logic [3:0]        sel = 4'h0;
	logic [31:0]       wdat = 32'h0, rdat, rnd = 32'h5020, w, d, mw, l0, l1;
	logic [1:0]        vld = 2'h0, rdyn;
	logic [1:0][31:0]  rxw = '0;
	a4t_line_t [1:0]   rxl, lbo;
	logic [31:0]       q [33];
	int                n_errors = 0, num_checks = 0, k, n;
	always #2 clk = ~clk;
	a4t_top i_a4t_top (.sys_clk_in(clk), .rstn_in(rstn), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.rx_word_valid_in(vld), .rx_word_in(rxw), .rx_line_in(rxl),
		.rx_line_out(lbo), .serial_out_pos_out(pos), .serial_out_neg_out(neg),
		.tx_ready_out(rdy), .tx_half_full_n_out(hn), .tx_fifo_full_n_out(fn),
		.rx_data_ready_n_out(rdyn));
	a4t_line_model i_a4t_line_model (.sys_clk_in(clk), .rstn_in(rstn),
		.pos_in(pos), .neg_in(neg), .loop_in(lbo), .line_out(rxl),
		.word_out(mw), .loop0_out(l0), .loop1_out(l1));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [31:0] framed(input logic [31:0] x, input logic s);
		return {s ? ^x[30:0] : ~^x[30:0], x[30:0]};
	endfunction : framed
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic wr_en, input logic [7:0] a,
		input logic [31:0] dv, output logic [31:0] qv);
		int c;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= wr_en; adr <= a; wdat <= dv;
		sel <= 4'hF;
		c = 0;
		do begin @(posedge clk); c++; end while (ack !== 1'b1 && c < 64);
		qv = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		if (ack !== 1'b1) chk("wb_ack", 32'h0, 32'h1);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		bus(1'b1, a, dv, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] e);
		bus(1'b0, a, 32'h0, d);
		chk(nm, d, e);
	endtask : rdc
	task automatic rx_rd(input logic [7:0] b, input logic hf, output logic [31:0] v);
		logic [31:0] x, y;
		bus(1'b0, hf ? b + REG_HIGH_OFS : b, 32'h0, x);
		bus(1'b0, hf ? b : b + REG_HIGH_OFS, 32'h0, y);
		v = hf ? {x[15:0], y[15:0]} : {y[15:0], x[15:0]};
	endtask : rx_rd
	task automatic push(input int i, input logic [31:0] v);
		@(posedge clk);
		vld[i] <= 1'b1; rxw[i] <= v;
		@(posedge clk);
		vld <= 2'h0;
	endtask : push
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rdc(REG_STATUS, "status", 32'h1F);
		rdc(REG_CTRL, "ctrl", 32'h05);
		rdc(8'h3C, "unmapped", 32'h0);
		wr(REG_CTRL, 32'h0);
		for (k = 0; k < 33; k++) begin
			rnd = lfsr(rnd);
			wr(REG_TX_LOW, rnd);
			wr(REG_TX_HIGH, rnd >> 16);
			if (k == 14) rdc(REG_STATUS, "status15", 32'h1E);
			if (k == 15) rdc(REG_STATUS, "status16", 32'h1C);
			if (k >= 31) rdc(REG_STATUS, "status32", 32'h18);
			if (k == 14) chk("half_pin15", {31'h0, hn}, 32'h1);
			if (k == 15) chk("half_pin16", {31'h0, hn}, 32'h0);
			if (k == 31) chk("full_pin", {31'h0, fn}, 32'h0);
		end
		wr(REG_CTRL, 32'h12);
		wr(REG_CMD, 32'h1);
		rdc(REG_STATUS, "status_mr", 32'h1F);
		rdc(REG_CTRL, "ctrl_mr", 32'h12);
		for (k = 0; k < 33; k++) begin
			rnd = lfsr(rnd);
			q[k] = rnd;
			push(0, rnd);
		end
		rdc(REG_STATUS, "rx_full", 32'h17);
		chk("rdy_pin", {30'h0, rdyn}, 32'h2);
		for (k = 0; k < 32; k++) begin
			rx_rd(REG_RX_BASE, k[0], w);
			chk("rx_word", w, (k == 31) ? q[32] : q[k]);
		end
		rdc(REG_STATUS, "rx_empty", 32'h1F);
		sense = rnd[3];
		wr(REG_CTRL, {26'h0, 4'h8, sense, 1'b1});
		rnd = lfsr(rnd);
		w = rnd;
		push(1, w);
		rx_rd(REG_RX_BASE + REG_RX_STRIDE, 1'b0, d);
		chk("rep_word", d, w);
		rdc(REG_STATUS, "rep_status", 32'h1E);
		// Transmit enabled, loopback on, high speed.
		wr(REG_CTRL, {26'h0, 4'h2, sense, 1'b1});
		n = 0;
		while (!(pos | neg) && n < 1000) begin @(posedge clk); n++; end
		chk("first_bit", {31'h0, n <= 625}, 32'h1);
		rdc(REG_STATUS, "tx_busy", 32'h3E);
		n = 0;
		while (rdy !== 1'b1 && n < 82000) begin @(posedge clk); n++; end
		chk("tx_ready", {31'h0, rdy}, 32'h1);
		chk("line_word", mw, framed(w, sense));
		chk("loop_rx1", l0, framed(w, sense));
		chk("loop_rx2", l1, framed(w, sense));
		conclude();
	end
endmodule : arinc429_transmit_loopback_tb
`default_nettype wire
